// ### verilog/fsp_defs.vh
// Constants of the flash self-program host controller
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH
// APB register byte offsets
`define FSP_OFF_CMD 4'h0
`define FSP_OFF_ADDR 4'h4
`define FSP_OFF_DATA 4'h8
`define FSP_OFF_STAT 4'hc
// Command codes written to the command register
`define FSP_OP_ERASE 3'h1
`define FSP_OP_LOAD 3'h2
`define FSP_OP_WRITE 3'h3
`define FSP_OP_LOCK 3'h4
`define FSP_OP_REEN 3'h5
// Control register patterns for the device
`define FSP_PAT_ERASE 8'h03
`define FSP_PAT_LOAD 8'h01
`define FSP_PAT_WRITE 8'h05
`define FSP_PAT_LOCK 8'h09
`define FSP_PAT_REEN 8'h11
// Control register bit positions
`define FSP_BIT_EN 0
`define FSP_BIT_BUSY 6
// Address pointer field layout
`define FSP_WORD_LSB 1
`define FSP_WORD_W 5
`define FSP_PAGE_LSB 6
`define FSP_PAGE_W 7
`define FSP_WORDS 32
// First page of the section that stays readable during programming
`define FSP_NO_READ_WHILE_WRITE_SECTION_FIRST 7'h60
// Lock value layout: writable field and forced-one positions
`define FSP_LOCK_FIELD 8'h3c
`define FSP_LOCK_ONES 8'hc3
`define FSP_LOCK_ZPTR 16'h0001
// Reset value of the data register: lo_b lock bit programmed
`define FSP_DATA_RST 16'h00ef
// Arming window in clock cycles, and wait before polling the enable bit
`define FSP_ARM_WIN 3'h4
`define FSP_SETTLE 3'h3
`endif

// ### verilog/fsp_sync.v
// Two-stage synchroniser, one per bit
`timescale 1ns/1ps
module fsp_sync #(
  parameter W = 9
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Data
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= din[i];
          sync_q <= meta_q;
        end
      end
      assign dout[i] = sync_q;
    end
  endgenerate
endmodule

// ### verilog/fsp_word_mask.v
// Record of temporary buffer words loaded since the last buffer erase
`timescale 1ns/1ps
module fsp_word_mask (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Update
  input wire set_en,
  input wire [4:0] set_idx,
  input wire clr,
  // State
  output wire [31:0] mask
);
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_word
      reg used_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          used_q <= 1'b0;
        end else if (clr) begin
          used_q <= 1'b0;
        end else if (set_en && set_idx == i) begin
          used_q <= 1'b1;
        end
      end
      assign mask[i] = used_q;
    end
  endgenerate
endmodule

// ### verilog/fsp_host.v
// Host controller that sequences flash self-programming commands into the device
`timescale 1ns/1ps
`include "fsp_defs.vh"
module fsp_host (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Device control register access
  output reg ctl_we_q,
  output reg [7:0] ctl_wdata_q,
  input wire [7:0] ctl_rdata,
  // Device store-program instruction and operands
  output reg store_program_instr_q,
  output reg [15:0] zptr_q,
  output reg [7:0] data_low_reg_q,
  output reg [7:0] data_high_reg_q,
  // Device status and system
  input wire eeprom_busy,
  input wire ready_irq,
  output reg irq_enable_q,
  output reg rww_access_ok_q
);
  localparam ST_IDLE = 5'h01;
  localparam ST_CTRL = 5'h02;
  localparam ST_ISSUE = 5'h04;
  localparam ST_WAIT = 5'h08;
  localparam ST_POLL = 5'h10;

  reg [4:0] state_q;
  reg [2:0] op_q;
  reg [2:0] cnt_q;
  reg [6:0] page_q;
  reg [4:0] word_q;
  reg [15:0] data_q;
  reg done_q;
  reg err_q;
  reg rww_hold_q;
  reg load_seen_q;
  wire [8:0] sync_out;
  wire [7:0] ctl_sync;
  wire eep_sync;
  wire [31:0] word_mask;
  wire acc;
  wire wr_acc;
  wire cmd_wr;
  wire [2:0] cmd_op;
  wire cmd_ok;
  wire mask_set;
  wire mask_clr;
  wire eep_lost;
  wire tgt_rww;
  wire map_ok;
  wire sel_cmd;
  wire sel_addr;
  wire sel_data;
  wire sel_stat;
  wire reg_wr;
  reg op_legal;
  reg [31:0] rd_word;
  reg [7:0] pat_d;
  reg [15:0] z_d;

  fsp_sync #(.W(9)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({eeprom_busy, ctl_rdata}),
    .dout(sync_out)
  );
  assign ctl_sync = sync_out[7:0];
  assign eep_sync = sync_out[8];

  // APB: access phase lasts two cycles; effects happen at the pready edge
  assign acc = psel & penable & pready;
  assign wr_acc = acc & pwrite;
  // Only aligned words of the first sixteen bytes are mapped; a write elsewhere has no effect
  assign map_ok = paddr[31:4] == 28'h0000000 && paddr[1:0] == 2'b00;
  assign sel_cmd = paddr[3:0] == `FSP_OFF_CMD;
  assign sel_addr = paddr[3:0] == `FSP_OFF_ADDR;
  assign sel_data = paddr[3:0] == `FSP_OFF_DATA;
  assign sel_stat = paddr[3:0] == `FSP_OFF_STAT;
  assign reg_wr = wr_acc & map_ok;
  assign cmd_wr = reg_wr & sel_cmd;
  assign cmd_op = pwdata[2:0];

  // Opcodes that start a device operation; a load also needs a word not yet loaded
  always @* begin
    op_legal = 1'b0;
    case (cmd_op)
      `FSP_OP_ERASE: begin
        op_legal = 1'b1;
      end
      `FSP_OP_LOAD: begin
        op_legal = !word_mask[word_q];
      end
      `FSP_OP_WRITE: begin
        op_legal = 1'b1;
      end
      `FSP_OP_LOCK: begin
        op_legal = 1'b1;
      end
      `FSP_OP_REEN: begin
        op_legal = 1'b1;
      end
      default: begin
        op_legal = 1'b0;
      end
    endcase
  end

  // Commands while busy or during an EEPROM write are refused
  assign cmd_ok = cmd_wr && state_q == ST_IDLE && !eep_sync && op_legal;

  assign tgt_rww = page_q < `FSP_NO_READ_WHILE_WRITE_SECTION_FIRST;

  // The mask follows what the device keeps in its buffer
  assign mask_set = state_q == ST_ISSUE && op_q == `FSP_OP_LOAD;
  assign eep_lost = eep_sync && load_seen_q;
  assign mask_clr = (state_q == ST_POLL && !ctl_sync[`FSP_BIT_EN] &&
                     (op_q == `FSP_OP_WRITE || op_q == `FSP_OP_REEN)) || eep_lost;

  fsp_word_mask u_mask (
    .pclk(pclk),
    .presetn(presetn),
    .set_en(mask_set),
    .set_idx(word_q),
    .clr(mask_clr),
    .mask(word_mask)
  );

  // Control pattern and pointer for the armed operation
  always @* begin
    pat_d = `FSP_PAT_LOAD;
    z_d = 16'h0000;
    case (op_q)
      `FSP_OP_ERASE: begin
        pat_d = `FSP_PAT_ERASE;
        z_d = {3'b000, page_q, 6'h00};
      end
      `FSP_OP_LOAD: begin
        pat_d = `FSP_PAT_LOAD;
        z_d = {3'b000, page_q, word_q, 1'b0};
      end
      `FSP_OP_WRITE: begin
        pat_d = `FSP_PAT_WRITE;
        z_d = {3'b000, page_q, 6'h00};
      end
      `FSP_OP_LOCK: begin
        pat_d = `FSP_PAT_LOCK;
        z_d = `FSP_LOCK_ZPTR;
      end
      `FSP_OP_REEN: begin
        pat_d = `FSP_PAT_REEN;
        z_d = {3'b000, page_q, 6'h00};
      end
      default: begin
        pat_d = `FSP_PAT_LOAD;
        z_d = 16'h0000;
      end
    endcase
  end

  // Sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      op_q <= 3'h0;
      cnt_q <= 3'h0;
      ctl_we_q <= 1'b0;
      ctl_wdata_q <= 8'h00;
      store_program_instr_q <= 1'b0;
      zptr_q <= 16'h0000;
      data_low_reg_q <= 8'h00;
      data_high_reg_q <= 8'h00;
      done_q <= 1'b0;
      rww_hold_q <= 1'b0;
      load_seen_q <= 1'b0;
    end else begin
      ctl_we_q <= 1'b0;
      store_program_instr_q <= 1'b0;
      if (eep_lost) begin
        load_seen_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (cmd_ok) begin
            op_q <= cmd_op;
            done_q <= 1'b0;
            state_q <= ST_CTRL;
          end
        end
        ST_CTRL: begin
          // Operands are set with the control write and stay stable for the instruction that follows
          ctl_we_q <= 1'b1;
          ctl_wdata_q <= pat_d;
          zptr_q <= z_d;
          if (op_q == `FSP_OP_LOCK) begin
            data_low_reg_q <= (data_q[7:0] & `FSP_LOCK_FIELD) | `FSP_LOCK_ONES;
            data_high_reg_q <= 8'h00;
          end else begin
            data_low_reg_q <= data_q[7:0];
            data_high_reg_q <= data_q[15:8];
          end
          state_q <= ST_ISSUE;
        end
        ST_ISSUE: begin
          // First cycle of the arming window, well inside four cycles
          store_program_instr_q <= 1'b1;
          cnt_q <= `FSP_SETTLE;
          if (op_q == `FSP_OP_LOAD) begin
            load_seen_q <= 1'b1;
          end
          if ((op_q == `FSP_OP_ERASE || op_q == `FSP_OP_WRITE) && tgt_rww) begin
            rww_hold_q <= 1'b1;
          end
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          // Synchroniser lag: the enable bit read back is stale for a few cycles
          if (cnt_q == 3'h1) begin
            state_q <= ST_POLL;
          end
          cnt_q <= cnt_q - 3'h1;
        end
        ST_POLL: begin
          // Length of the operation is whatever the device takes
          if (!ctl_sync[`FSP_BIT_EN]) begin
            if (op_q == `FSP_OP_REEN || op_q == `FSP_OP_LOAD) begin
              rww_hold_q <= 1'b0;
            end
            if (op_q == `FSP_OP_WRITE || op_q == `FSP_OP_REEN) begin
              load_seen_q <= 1'b0;
            end
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Address, data, error flag and system outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= 7'h00;
      word_q <= 5'h00;
      data_q <= `FSP_DATA_RST;
      err_q <= 1'b0;
      irq_enable_q <= 1'b0;
      rww_access_ok_q <= 1'b0;
    end else begin
      if (reg_wr && sel_addr && state_q == ST_IDLE) begin
        page_q <= pwdata[`FSP_PAGE_LSB+`FSP_PAGE_W-1:`FSP_PAGE_LSB];
        word_q <= pwdata[`FSP_WORD_LSB+`FSP_WORD_W-1:`FSP_WORD_LSB];
      end
      if (reg_wr && sel_data && state_q == ST_IDLE) begin
        data_q <= pwdata[15:0];
      end
      // A refusal in the same cycle as a clear still sets the flag
      if (cmd_wr && !cmd_ok) begin
        err_q <= 1'b1;
      end else if (reg_wr && sel_stat && pwdata[2]) begin
        err_q <= 1'b0;
      end
      // Ready interrupt passes only while idle; vectors may sit in the blocked section
      irq_enable_q <= state_q == ST_IDLE && ready_irq;
      rww_access_ok_q <= !rww_hold_q && !ctl_sync[`FSP_BIT_BUSY];
    end
  end

  // Read mux; the answer register below keeps prdata straight from a flop
  always @* begin
    rd_word = 32'h00000000;
    case (paddr[3:0])
      `FSP_OFF_CMD: begin
        rd_word = {29'h00000000, op_q};
      end
      `FSP_OFF_ADDR: begin
        rd_word = {16'h0000, 3'h0, page_q, word_q, 1'b0};
      end
      `FSP_OFF_DATA: begin
        rd_word = {16'h0000, data_q};
      end
      `FSP_OFF_STAT: begin
        rd_word = {15'h0000, rww_access_ok_q, ctl_sync, 5'h00, err_q, done_q, state_q != ST_IDLE};
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // APB answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && penable && !pready) begin
        if (!map_ok) begin
          pslverr <= 1'b1;
        end else if (!pwrite) begin
          prdata <= rd_word;
        end
      end
    end
  end
endmodule

// ### testbench/fsp_host_sva.sv
// Port-level checks for the flash self-program host controller
`timescale 1ns/1ps
`include "fsp_defs.vh"
module fsp_host_sva (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pready,
  // Device link
  input wire ctl_we_q,
  input wire [7:0] ctl_wdata_q,
  input wire store_program_instr_q,
  input wire [15:0] zptr_q,
  input wire [7:0] data_low_reg_q,
  input wire irq_enable_q,
  input wire rww_access_ok_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  sequence s_arm; ctl_we_q; endsequence
  sequence s_prog; store_program_instr_q && ctl_wdata_q inside {`FSP_PAT_ERASE, `FSP_PAT_WRITE}; endsequence
  property p_apb_wait; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
  property p_arm_spm; s_arm |=> store_program_instr_q && $stable(zptr_q) && $stable(ctl_wdata_q); endproperty
  property p_spm_armed; store_program_instr_q |-> $past(ctl_we_q); endproperty
  property p_pattern; s_arm |-> ctl_wdata_q inside {8'h03, 8'h01, 8'h05, 8'h09, 8'h11}; endproperty
  property p_lock_ones; s_arm and ctl_wdata_q == `FSP_PAT_LOCK |-> (data_low_reg_q & 8'hc3) == 8'hc3; endproperty
  property p_page_only;
    s_arm ##0 (ctl_wdata_q inside {`FSP_PAT_ERASE, `FSP_PAT_WRITE}) |-> zptr_q[5:0] == 6'h0 && zptr_q[15:13] == 3'h0;
  endproperty
  // Readability is seen through a two-stage synchroniser, hence the window
  property p_rww_block; s_prog and zptr_q[12:6] < `FSP_NO_READ_WHILE_WRITE_SECTION_FIRST |-> ##[1:6] !rww_access_ok_q; endproperty
  property p_no_read_while_write_section_open; s_prog and zptr_q[12:6] >= `FSP_NO_READ_WHILE_WRITE_SECTION_FIRST && rww_access_ok_q |=> rww_access_ok_q [*4]; endproperty
  property p_irq_quiet; store_program_instr_q |-> !irq_enable_q; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer late or early");
  a_arm_spm: assert property (p_arm_spm) else $error("instruction not after control write");
  a_spm_armed: assert property (p_spm_armed) else $error("instruction without control write");
  a_pattern: assert property (p_pattern) else $error("illegal control pattern");
  a_lock_ones: assert property (p_lock_ones) else $error("lock fill bits not ones");
  a_page_only: assert property (p_page_only) else $error("pointer has word bits");
  a_rww_block: assert property (p_rww_block) else $error("section not blocked");
  a_no_read_while_write_section_open: assert property (p_no_read_while_write_section_open) else $error("section blocked needlessly");
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq enabled during operation");
endmodule
bind fsp_host fsp_host_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .ctl_we_q(ctl_we_q), .ctl_wdata_q(ctl_wdata_q), .store_program_instr_q(store_program_instr_q), .zptr_q(zptr_q),
  .data_low_reg_q(data_low_reg_q), .irq_enable_q(irq_enable_q), .rww_access_ok_q(rww_access_ok_q));

// ### testbench/fsp_dev_model.sv
// Behavioural device: control register, arming window and busy timing
`timescale 1ns/1ps
module fsp_dev_model #(
  parameter DUR = 20
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control and instruction
  input wire ctl_we_q,
  input wire [7:0] ctl_wdata_q,
  input wire store_program_instr_q,
  input wire [15:0] zptr_q,
  // Status
  output wire [7:0] ctl_rdata,
  output wire ready_irq
);
  logic en_q, busy_q;
  logic [2:0] win_q;
  logic [7:0] cnt_q;
  logic [4:0] op_q;
  assign ctl_rdata = {1'b0, busy_q, 5'h0, en_q};
  assign ready_irq = !en_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
      busy_q <= 1'b0;
      win_q <= 3'h0;
      cnt_q <= 8'h0;
      op_q <= 5'h0;
    end else if (ctl_we_q && !en_q && ctl_wdata_q[4:0] inside {5'h03, 5'h01, 5'h05, 5'h09, 5'h11}) begin
      en_q <= 1'b1;
      op_q <= ctl_wdata_q[4:0];
      win_q <= 3'h4;
    end else if (cnt_q != 8'h0) begin
      cnt_q <= cnt_q - 8'h1;
      en_q <= cnt_q != 8'h1;
    end else if (en_q && store_program_instr_q) begin
      // Only the page field picks the section; the data registers play no part
      if (op_q == 5'h03 || op_q == 5'h05) begin
        cnt_q <= DUR[7:0];
        busy_q <= busy_q || zptr_q[12:6] < 7'h60;
      end else begin
        en_q <= 1'b0;
        if (op_q != 5'h09)
          busy_q <= 1'b0;
      end
    end else if (en_q) begin
      win_q <= win_q - 3'h1;
      en_q <= win_q != 3'h1;
    end
  end
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the flash self-program host controller
`timescale 1ns/1ps
`include "fsp_defs.vh"
module tb_top;
  localparam logic [31:0] ad_cmd = {28'h0, `FSP_OFF_CMD};
  localparam logic [31:0] ad_data = {28'h0, `FSP_OFF_DATA};
  localparam logic [31:0] ad_addr = {28'h0, `FSP_OFF_ADDR};
  localparam logic [31:0] ad_stat = {28'h0, `FSP_OFF_STAT};
  localparam logic [31:0] m_st = 32'h0001_4007;
  localparam logic [39:0] m_full = 40'hff_ffff_ffff;
  localparam logic [39:0] m_pg = 40'hffff_0000_ff;
  logic pclk, presetn, psel, penable, pwrite, eeprom_busy;
  logic [31:0] paddr, pwdata, rd, lfsr, m;
  logic [32:0] e;
  logic [39:0] le, lm;
  logic [32:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [39:0] lq[$];
  logic [39:0] lmq[$];
  int num_errors = 0;
  int n_tests = 0;
  wire [31:0] prdata;
  wire pready, pslverr, ctl_we_q, store_program_instr, ready_irq, irq_en, rww_ok;
  wire [7:0] ctl_wdata_q, ctl_rdata, dlo, dhi;
  wire [15:0] zptr_q;
  fsp_host dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctl_we_q(ctl_we_q),
    .ctl_wdata_q(ctl_wdata_q), .ctl_rdata(ctl_rdata), .store_program_instr_q(store_program_instr), .zptr_q(zptr_q),
    .data_low_reg_q(dlo), .data_high_reg_q(dhi), .eeprom_busy(eeprom_busy), .ready_irq(ready_irq),
    .irq_enable_q(irq_en), .rww_access_ok_q(rww_ok));
  fsp_dev_model #(.DUR(20)) dev_u (.pclk(pclk), .presetn(presetn), .ctl_we_q(ctl_we_q),
    .ctl_wdata_q(ctl_wdata_q), .store_program_instr_q(store_program_instr), .zptr_q(zptr_q), .ctl_rdata(ctl_rdata),
    .ready_irq(ready_irq));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic finish_test();
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk_apb(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH apb t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_link(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH link t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [32:0] ex,
                     input logic [31:0] mk);
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Issue a command and queue its device link check, poll until idle, then check status and the irq enable
  task automatic cmd(input logic [2:0] op, input logic [39:0] lex, input logic [39:0] lmk, input logic [31:0] se,
                     input logic [31:0] sm);
    if (lmk != 40'h0) begin
      lq.push_back(lex);
      lmq.push_back(lmk);
    end
    apb(1'b1, ad_cmd, {29'h0, op}, 33'h0, 32'h0);
    do apb(1'b0, ad_stat, 32'h0, 33'h0, 32'h0); while (rd[0] !== 1'b0);
    apb(1'b0, ad_stat, 32'h0, {1'b0, se}, sm);
    chk_apb({32'h0, irq_en}, 33'h1);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      chk_apb({pslverr, prdata & m}, {e[32], e[31:0] & m});
    end
    if (ctl_we_q === 1'b1) begin
      le = lq.pop_front();
      lm = lmq.pop_front();
      chk_link({zptr_q, dhi, dlo, ctl_wdata_q} & lm, le & lm);
    end
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    finish_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, eeprom_busy} = 5'h0;
    {paddr, pwdata} = 64'h0;
    lfsr = 32'hba494a26;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ad_data, 32'h0, 33'h0_0000_00ef, 32'hffff);
    apb(1'b0, ad_stat, 32'h0, 33'h0_0001_0000, m_st);
    apb(1'b0, 32'h10, 32'h0, 33'h1_0000_0000, 32'h0);
    apb(1'b1, ad_addr, 32'h406, 33'h0, 32'h0);
    apb(1'b1, 32'h14, 32'h0, 33'h1_0000_0000, 32'h0);
    apb(1'b1, ad_data, 32'hbeef, 33'h0, 32'h0);
    cmd(`FSP_OP_LOAD, 40'h0406_beef_01, m_full, 32'h1_0002, m_st);
    cmd(`FSP_OP_LOAD, 40'h0, 40'h0, 32'h4, 32'h4);
    apb(1'b1, ad_stat, 32'h4, 33'h0, 32'h0);
    cmd(`FSP_OP_ERASE, 40'h0400_0000_03, m_pg, 32'h0_4002, m_st);
    cmd(`FSP_OP_REEN, 40'h0400_0000_11, m_pg, 32'h1_0002, m_st);
    cmd(`FSP_OP_LOAD, 40'h0406_beef_01, m_full, 32'h1_0002, m_st);
    eeprom_busy <= 1'b1;
    repeat (4) @(posedge pclk);
    cmd(`FSP_OP_LOAD, 40'h0, 40'h0, 32'h4, 32'h4);
    eeprom_busy <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, ad_stat, 32'h4, 33'h0, 32'h0);
    cmd(`FSP_OP_LOAD, 40'h0406_beef_01, m_full, 32'h1_0002, m_st);
    apb(1'b1, ad_addr, 32'h400, 33'h0, 32'h0);
    cmd(`FSP_OP_WRITE, 40'h0400_0000_05, m_pg, 32'h0_4002, m_st);
    cmd(`FSP_OP_REEN, 40'h0400_0000_11, m_pg, 32'h1_0002, m_st);
    cmd(`FSP_OP_LOAD, 40'h0400_beef_01, m_full, 32'h1_0002, m_st);
    apb(1'b1, ad_addr, 32'h1c00, 33'h0, 32'h0);
    cmd(`FSP_OP_WRITE, 40'h1c00_0000_05, m_pg, 32'h1_0002, m_st);
    cmd(`FSP_OP_ERASE, 40'h1c00_0000_03, m_pg, 32'h1_0002, m_st);
    for (int i = 0; i < 3; i++) begin
      lfsr = nx(lfsr);
      apb(1'b1, ad_data, {16'h0, lfsr[15:0]}, 33'h0, 32'h0);
      cmd(`FSP_OP_LOCK, {16'h0001, 8'h00, lfsr[7:0] & 8'h3c | 8'hc3, 8'h09}, m_full, 32'h1_0002, m_st);
      apb(1'b1, ad_addr, {19'h0, 7'h10, 5'(8 + i), 1'b0}, 33'h0, 32'h0);
      cmd(`FSP_OP_LOAD, {16'h0400 + 16'((8 + i) * 2), lfsr[15:0], 8'h01}, m_full, 32'h1_0002, m_st);
    end
    apb(1'b0, ad_cmd, 32'h0, 33'h2, 32'h7);
    for (int i = 5; i < 8; i++) begin
      cmd(3'((i + 1) % 8), 40'h0, 40'h0, 32'h4, 32'h4);
      apb(1'b1, ad_stat, 32'h4, 33'h0, 32'h0);
    end
    finish_test();
  end
endmodule
